// File: logic/jpcd_top.sv
`timescale 1ns/1ps

module jpcd_top (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic tck_in,
  input wire logic tdi_in,
  input wire logic capture_dr_in,
  input wire logic shift_dr_in,
  input wire logic update_dr_in,
  input wire logic run_idle_in,
  input wire logic sel_enable_in,
  input wire logic sel_command_in,
  output logic tdo_out,
  input wire logic nv_done_in,
  input wire logic [15:0] nv_rdata_in,
  input wire logic [7:0] lock_cur_in,
  output logic nv_start_out,
  output jpcd_pkg::jpcd_nv_cmd_t nv_cmd_out,
  output logic prog_enabled_out
);

  // ----------------------------------------------------------------
  // Test clock domain state
  // ----------------------------------------------------------------
  logic [15:0] en_shift, en_reg, req_addr, req_data;
  logic [14:0] cmd_shift, cmd_word, result;
  logic [7:0] mode, addr_hi, addr_lo, data_lo, data_hi, opnd, hi_mask, res_byte;
  logic armed, res_hi, req_tgl, ack_s1, ack_s2, enabled, done, exec, issue;
  logic [6:0] opc;
  jpcd_pkg::jpcd_nv_op_t req_op, next_op;

  // ----------------------------------------------------------------
  // System clock domain state
  // ----------------------------------------------------------------
  logic req_s1, req_s2, req_s3, busy, ack_tgl, en_s1, en_s2, req_edge;
  logic [15:0] rdata;

  // ----------------------------------------------------------------
  // Command field split and decode
  // ----------------------------------------------------------------
  // opcode and operand
  assign opc = cmd_word[14:8];
  assign opnd = cmd_word[7:0];

  assign enabled = (en_reg == jpcd_pkg::ENABLE_SIGNATURE);

  assign done = (ack_s2 == req_tgl);

  assign exec = run_idle_in && armed && enabled;

  always_comb begin
    next_op = jpcd_pkg::NV_NONE;
    case (mode)
      jpcd_pkg::MODE_ERASE: if (opc == jpcd_pkg::OPC_STB_LO) next_op = jpcd_pkg::NV_ERASE;
      jpcd_pkg::MODE_FLASH_WR: begin
        if (opc == jpcd_pkg::OPC_LATCH) next_op = jpcd_pkg::NV_LATCH;
        if (opc == jpcd_pkg::OPC_STB_HI) next_op = jpcd_pkg::NV_PAGE_WR;
      end
      jpcd_pkg::MODE_FLASH_RD: if (opc == jpcd_pkg::OPC_RD_A) next_op = jpcd_pkg::NV_FLASH_RD;
      jpcd_pkg::MODE_EE_WR: if (opc == jpcd_pkg::OPC_STB_LO) next_op = jpcd_pkg::NV_EE_WR;
      jpcd_pkg::MODE_EE_RD: if (opc == jpcd_pkg::OPC_RD_A) next_op = jpcd_pkg::NV_EE_RD;
      jpcd_pkg::MODE_FUSE_WR: begin
        if (opc == jpcd_pkg::OPC_STB_HI) next_op = jpcd_pkg::NV_FUSE_HI_WR;
        if (opc == jpcd_pkg::OPC_STB_LO) next_op = jpcd_pkg::NV_FUSE_LO_WR;
      end
      jpcd_pkg::MODE_LOCK_WR: if (opc == jpcd_pkg::OPC_STB_LO) next_op = jpcd_pkg::NV_LOCK_WR;
      jpcd_pkg::MODE_FL_RD: begin
        if (opc == jpcd_pkg::OPC_RD_F) next_op = jpcd_pkg::NV_FUSE_HI_RD;
        if (opc == jpcd_pkg::OPC_RD_A) next_op = jpcd_pkg::NV_FUSE_LO_RD;
        if (opc == jpcd_pkg::OPC_RD_B) next_op = jpcd_pkg::NV_LOCK_RD;
      end
      jpcd_pkg::MODE_ID_RD: begin
        if (opc == jpcd_pkg::OPC_RD_A) next_op = jpcd_pkg::NV_SIG_RD;
        if (opc == jpcd_pkg::OPC_RD_B) next_op = jpcd_pkg::NV_CAL_RD;
      end
      default: next_op = jpcd_pkg::NV_NONE;
    endcase
  end

  assign issue = exec && (next_op != jpcd_pkg::NV_NONE);

  always_comb begin
    case (mode)
      jpcd_pkg::MODE_EE_WR, jpcd_pkg::MODE_EE_RD: hi_mask = jpcd_pkg::EE_HI_MASK;
      jpcd_pkg::MODE_ID_RD: hi_mask = jpcd_pkg::BYTE_RESET;
      default: hi_mask = jpcd_pkg::FLASH_HI_MASK;
    endcase
  end

  // ----------------------------------------------------------------
  // Programming enable register
  // ----------------------------------------------------------------
  // enable shift path
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_shift <= jpcd_pkg::ENABLE_RESET;
    end else if (shift_dr_in && sel_enable_in) begin
      en_shift <= {tdi_in, en_shift[15:1]};
    end
  end

  // cleared at power-on, loaded on update
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_reg <= jpcd_pkg::ENABLE_RESET;
    end else if (update_dr_in && sel_enable_in) begin
      en_reg <= en_shift;
    end
  end

  // ----------------------------------------------------------------
  // Programming command register
  // ----------------------------------------------------------------
  assign res_byte = res_hi ? rdata[15:8] : rdata[7:0];
  assign result = {5'h00, done, 1'b0, res_byte};

  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_shift <= jpcd_pkg::CMD_RESET;
    end else if (capture_dr_in && sel_command_in) begin
      cmd_shift <= result;
    end else if (shift_dr_in && sel_command_in) begin
      cmd_shift <= {tdi_in, cmd_shift[14:1]};
    end
  end

  // apply on update only when enabled
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_word <= jpcd_pkg::CMD_RESET;
      armed <= 1'b0;
    end else if (update_dr_in && sel_command_in && enabled) begin
      cmd_word <= cmd_shift;
      armed <= 1'b1;
    end else if (run_idle_in) begin
      armed <= 1'b0;
    end
  end

  assign tdo_out = sel_enable_in ? en_shift[0] : cmd_shift[0];

  // ----------------------------------------------------------------
  // Operand registers and function select
  // ----------------------------------------------------------------
  // loads and no-operation
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode <= jpcd_pkg::MODE_NOP;
      addr_hi <= jpcd_pkg::BYTE_RESET;
      addr_lo <= jpcd_pkg::BYTE_RESET;
      data_lo <= jpcd_pkg::BYTE_RESET;
      data_hi <= jpcd_pkg::BYTE_RESET;
    end else if (!enabled) begin
      mode <= jpcd_pkg::MODE_NOP;
    end else if (exec) begin
      case (opc)
        jpcd_pkg::OPC_ENTER: mode <= opnd;
        jpcd_pkg::OPC_ADDR_HI: addr_hi <= opnd;
        jpcd_pkg::OPC_ADDR_LO: addr_lo <= opnd;
        jpcd_pkg::OPC_DATA_LO: data_lo <= opnd;
        jpcd_pkg::OPC_DATA_HI: data_hi <= opnd;
        default: mode <= mode;
      endcase
    end
  end

  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_hi <= 1'b0;
    end else if (exec) begin
      res_hi <= (mode == jpcd_pkg::MODE_FLASH_RD) && (opc == jpcd_pkg::OPC_RD_BHI);
    end
  end

  // ----------------------------------------------------------------
  // Request launch and acknowledge crossing
  // ----------------------------------------------------------------
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_op <= jpcd_pkg::NV_NONE;
      req_addr <= jpcd_pkg::WORD_RESET;
      req_data <= jpcd_pkg::WORD_RESET;
      req_tgl <= 1'b0;
    end else if (issue) begin
      req_op <= next_op;
      req_addr <= {addr_hi & hi_mask, addr_lo};
      req_data <= {data_hi, data_lo};
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // ----------------------------------------------------------------
  // System clock side of the nonvolatile port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else begin
      req_s1 <= req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      en_s1 <= enabled;
      en_s2 <= en_s1;
    end
  end

  assign req_edge = req_s2 ^ req_s3;
  assign prog_enabled_out = en_s2;

  // fuse fixed ones, lock never unprograms
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      nv_cmd_out <= '0;
      nv_start_out <= 1'b0;
    end else begin
      nv_start_out <= req_edge;
      if (req_edge) begin
        nv_cmd_out.op <= req_op;
        nv_cmd_out.addr <= req_addr;
        case (req_op)
          jpcd_pkg::NV_FUSE_HI_WR, jpcd_pkg::NV_FUSE_LO_WR:
            nv_cmd_out.data <= {8'h00, req_data[7:0] | jpcd_pkg::FUSE_FIXED_ONES};
          jpcd_pkg::NV_LOCK_WR:
            nv_cmd_out.data <= {8'h00, req_data[7:0] & lock_cur_in};
          jpcd_pkg::NV_LATCH:
            nv_cmd_out.data <= req_data;
          default:
            nv_cmd_out.data <= {8'h00, req_data[7:0]};
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      ack_tgl <= 1'b0;
      rdata <= jpcd_pkg::WORD_RESET;
    end else if (nv_start_out) begin
      busy <= 1'b1;
    end else if (busy && nv_done_in) begin
      busy <= 1'b0;
      ack_tgl <= ~ack_tgl;
      rdata <= nv_rdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_enable_match: assert property (
    @(posedge tck_in) disable iff (!arst_n_in)
    update_dr_in && sel_enable_in |=>
      enabled == ($past(en_shift) == jpcd_pkg::ENABLE_SIGNATURE))
    else $error("enable compare wrong");
  a_locked_no_issue: assert property (
    @(posedge tck_in) disable iff (!arst_n_in)
    !enabled |=> req_tgl == $past(req_tgl))
    else $error("request while disabled");
  a_cmd_shift_lsb: assert property (
    @(posedge tck_in) disable iff (!arst_n_in)
    shift_dr_in && sel_command_in && !capture_dr_in |=>
      cmd_shift == {$past(tdi_in), $past(cmd_shift[14:1])})
    else $error("command shift order wrong");
  a_capture_poll: assert property (
    @(posedge tck_in) disable iff (!arst_n_in)
    capture_dr_in && sel_command_in |=> cmd_shift[jpcd_pkg::POLL_BIT] == $past(done))
    else $error("poll flag not captured");
  a_single_exec: assert property (
    @(posedge tck_in) disable iff (!arst_n_in)
    exec |=> !exec)
    else $error("command executed twice");
  a_req_reaches: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    $changed(req_s1) |-> ##2 nv_start_out)
    else $error("request not started");
  a_start_busy: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    nv_start_out |=> busy && !nv_start_out)
    else $error("start without busy");
  a_lock_keep: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    nv_start_out && nv_cmd_out.op == jpcd_pkg::NV_LOCK_WR |->
      (nv_cmd_out.data[7:0] & ~$past(lock_cur_in)) == 8'h00)
    else $error("lock bit unprogrammed");
  a_fuse_fixed: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    nv_start_out && (nv_cmd_out.op == jpcd_pkg::NV_FUSE_HI_WR ||
      nv_cmd_out.op == jpcd_pkg::NV_FUSE_LO_WR) |->
      (nv_cmd_out.data[7:0] & jpcd_pkg::FUSE_FIXED_ONES) == jpcd_pkg::FUSE_FIXED_ONES)
    else $error("fixed fuse bits not one");
  a_done_ack: assert property (
    @(posedge mclk_in) disable iff (!arst_n_in)
    busy && nv_done_in && !nv_start_out |=> !busy && ack_tgl != $past(ack_tgl))
    else $error("completion not acknowledged");

  c_enabled: cover property (@(posedge tck_in) disable iff (!arst_n_in) $rose(enabled));
  c_erase: cover property (@(posedge tck_in) disable iff (!arst_n_in)
    issue && next_op == jpcd_pkg::NV_ERASE);
  c_flash_rd: cover property (@(posedge tck_in) disable iff (!arst_n_in)
    issue && next_op == jpcd_pkg::NV_FLASH_RD);
  c_done: cover property (@(posedge mclk_in) disable iff (!arst_n_in)
    busy && nv_done_in);

endmodule : jpcd_top

// File: inc/jpcd_pkg.sv
package jpcd_pkg;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int ENABLE_W = 16;
  localparam int CMD_W = 15;
  localparam int OPC_W = 7;
  localparam int OPND_W = 8;
  localparam int OPC_LSB = 8;
  localparam int POLL_BIT = 9;

  // ----------------------------------------------------------------
  // Reset values and signature
  // ----------------------------------------------------------------
  localparam logic [15:0] ENABLE_SIGNATURE = 16'ha370;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [14:0] CMD_RESET = 15'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Opcode field values
  // ----------------------------------------------------------------
  localparam logic [6:0] OPC_ENTER = 7'h23;
  localparam logic [6:0] OPC_ADDR_HI = 7'h07;
  localparam logic [6:0] OPC_ADDR_LO = 7'h03;
  localparam logic [6:0] OPC_DATA_LO = 7'h13;
  localparam logic [6:0] OPC_DATA_HI = 7'h17;
  localparam logic [6:0] OPC_LATCH = 7'h77;
  localparam logic [6:0] OPC_STB_HI = 7'h35;
  localparam logic [6:0] OPC_STB_LO = 7'h31;
  localparam logic [6:0] OPC_RD_A = 7'h32;
  localparam logic [6:0] OPC_RD_B = 7'h36;
  localparam logic [6:0] OPC_RD_BHI = 7'h37;
  localparam logic [6:0] OPC_RD_F = 7'h3e;

  // ----------------------------------------------------------------
  // Function select codes carried by the enter command
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_NOP = 8'h00;
  localparam logic [7:0] MODE_ERASE = 8'h80;
  localparam logic [7:0] MODE_FLASH_WR = 8'h10;
  localparam logic [7:0] MODE_FLASH_RD = 8'h02;
  localparam logic [7:0] MODE_EE_WR = 8'h11;
  localparam logic [7:0] MODE_EE_RD = 8'h03;
  localparam logic [7:0] MODE_FUSE_WR = 8'h40;
  localparam logic [7:0] MODE_LOCK_WR = 8'h20;
  localparam logic [7:0] MODE_FL_RD = 8'h04;
  localparam logic [7:0] MODE_ID_RD = 8'h08;

  // ----------------------------------------------------------------
  // Address and data masks
  // ----------------------------------------------------------------
  localparam logic [7:0] FLASH_HI_MASK = 8'h3f;
  localparam logic [7:0] EE_HI_MASK = 8'h03;
  localparam logic [7:0] FUSE_FIXED_ONES = 8'h30;

  // ----------------------------------------------------------------
  // Nonvolatile operations and request word
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NV_NONE, NV_ERASE, NV_LATCH, NV_PAGE_WR, NV_FLASH_RD, NV_EE_WR, NV_EE_RD,
    NV_FUSE_HI_WR, NV_FUSE_LO_WR, NV_LOCK_WR, NV_FUSE_HI_RD, NV_FUSE_LO_RD,
    NV_LOCK_RD, NV_SIG_RD, NV_CAL_RD
  } jpcd_nv_op_t;

  typedef struct packed {
    jpcd_nv_op_t op;
    logic [15:0] addr;
    logic [15:0] data;
  } jpcd_nv_cmd_t;

endpackage : jpcd_pkg

// File: tb/jpcd_nv_model.sv
`timescale 1ns/1ps
module jpcd_nv_model (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic nv_start_in,
  input wire jpcd_pkg::jpcd_nv_cmd_t nv_cmd_in,
  input wire logic [7:0] dly_in,
  output logic nv_done_out,
  output logic [15:0] nv_rdata_out,
  output int starts_out
);
  // ------------------------------------------------
  // Array responder
  // ------------------------------------------------
  logic [7:0] cnt;
  logic busy;
  logic [15:0] word;
  assign word = {4'ha, nv_cmd_in.op, 4'h5, nv_cmd_in.op};
  // Data valid only with done, inverted otherwise
  assign nv_rdata_out = nv_done_out ? word : ~word;
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      nv_done_out <= 1'b0;
      starts_out <= 0;
    end else begin
      nv_done_out <= 1'b0;
      if (nv_start_in) begin
        busy <= 1'b1;
        cnt <= dly_in;
        starts_out <= starts_out + 1;
      end else if (busy) begin
        cnt <= cnt - 8'h01;
        if (cnt <= 8'h01) begin
          busy <= 1'b0;
          nv_done_out <= 1'b1;
        end
      end
    end
  end
endmodule : jpcd_nv_model

// File: tb/test_jtag_prog_command_decoder.sv
`timescale 1ns/1ps
module test_jtag_prog_command_decoder;
  logic mclk, tck, arst_n, tdi, cap, sh, upd, ri, sel_en, sel_cmd, tdo;
  logic nv_done, nv_start, prog_en;
  logic [15:0] nv_rdata;
  logic [7:0] lock_cur, dly;
  jpcd_pkg::jpcd_nv_cmd_t nv_cmd;
  int starts, fails, checked, cyc;

  jpcd_top jpcd_top_inst (.mclk_in(mclk), .arst_n_in(arst_n), .tck_in(tck),
    .tdi_in(tdi), .capture_dr_in(cap), .shift_dr_in(sh), .update_dr_in(upd),
    .run_idle_in(ri), .sel_enable_in(sel_en), .sel_command_in(sel_cmd),
    .tdo_out(tdo), .nv_done_in(nv_done), .nv_rdata_in(nv_rdata),
    .lock_cur_in(lock_cur), .nv_start_out(nv_start), .nv_cmd_out(nv_cmd),
    .prog_enabled_out(prog_en));
  jpcd_nv_model jpcd_nv_model_inst (.mclk_in(mclk), .arst_n_in(arst_n),
    .nv_start_in(nv_start), .nv_cmd_in(nv_cmd), .dly_in(dly),
    .nv_done_out(nv_done), .nv_rdata_out(nv_rdata), .starts_out(starts));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    tck = 1'b0;
    #37;
    forever #80 tck = ~tck;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      conclude();
    end
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Enable (en=1, 16 bits) or command frame (15 bits, with capture)
  task automatic tap(input bit en, input logic [15:0] v, output logic [15:0] r);
    int n;
    n = en ? 16 : 15;
    r = 16'h0000;
    @(posedge tck);
    sel_en <= en;
    sel_cmd <= !en;
    cap <= !en;
    @(posedge tck);
    cap <= 1'b0;
    sh <= 1'b1;
    tdi <= v[0];
    for (int i = 0; i < n; i++) begin
      @(negedge tck);
      r[i] = tdo;
      @(posedge tck);
      if (i < n - 1) tdi <= v[i + 1];
      else begin
        sh <= 1'b0;
        upd <= 1'b1;
      end
    end
    @(posedge tck);
    upd <= 1'b0;
    ri <= 1'b1;
    @(posedge tck);
    ri <= 1'b0;
  endtask : tap

  task automatic strobe(input logic [15:0] w, input logic [15:0] p,
                        input jpcd_pkg::jpcd_nv_op_t op, output logic [15:0] r);
    int s0, k;
    s0 = starts;
    k = 0;
    tap(0, w, r);
    do begin
      tap(0, p, r);
      k++;
    end while (r[9] !== 1'b1 && k < 20);
    cmp(r[9], 1'b1);
    cmp(36'(starts - s0), 36'h1);
    cmp(nv_cmd.op, op);
  endtask : strobe

  function automatic logic [35:0] res(input logic [7:0] b);
    return {21'h0, 5'h00, 1'b1, 1'b0, b};
  endfunction : res

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic t_reset;
    logic [15:0] r;
    cmp(prog_en, 1'b0);
    tap(1, 16'ha371, r);
    cmp(r, 16'h0000);
    cmp(prog_en, 1'b0);
    tap(0, 16'h2380, r);
    tap(0, 16'h3180, r);
    tap(0, 16'h3380, r);
    cmp(36'(starts), 36'h0);
  endtask : t_reset

  task automatic t_enable;
    logic [15:0] r;
    tap(1, jpcd_pkg::ENABLE_SIGNATURE, r);
    cmp(r, 16'ha371);
    cmp(prog_en, 1'b1);
  endtask : t_enable

  task automatic t_erase;
    logic [15:0] r;
    @(posedge mclk) dly <= 8'd150;
    tap(0, 16'h2380, r);
    strobe(16'h3180, 16'h3380, jpcd_pkg::NV_ERASE, r);
    @(posedge mclk) dly <= 8'd2;
  endtask : t_erase

  task automatic t_flash;
    logic [15:0] r;
    tap(0, 16'h2310, r);
    tap(0, 16'h07ff, r);
    tap(0, 16'h035a, r);
    tap(0, 16'h1334, r);
    tap(0, 16'h1712, r);
    strobe(16'h7700, 16'h3700, jpcd_pkg::NV_LATCH, r);
    cmp(nv_cmd.addr, 16'h3f5a);
    cmp(nv_cmd.data, 16'h1234);
    strobe(16'h3500, 16'h3700, jpcd_pkg::NV_PAGE_WR, r);
    tap(0, 16'h2302, r);
    tap(0, 16'h0701, r);
    tap(0, 16'h0380, r);
    strobe(16'h3200, 16'h3600, jpcd_pkg::NV_FLASH_RD, r);
    cmp(nv_cmd.addr, 16'h0180);
    cmp(r[14:0], res({4'h5, jpcd_pkg::NV_FLASH_RD}));
    tap(0, 16'h3700, r);
    tap(0, 16'h3300, r);
    cmp(r[14:0], res({4'ha, jpcd_pkg::NV_FLASH_RD}));
  endtask : t_flash

  task automatic t_eeprom;
    logic [15:0] r;
    tap(0, 16'h2311, r);
    tap(0, 16'h07ff, r);
    tap(0, 16'h03c4, r);
    tap(0, 16'h13a5, r);
    strobe(16'h3100, 16'h3300, jpcd_pkg::NV_EE_WR, r);
    cmp(nv_cmd.addr, 16'h03c4);
    cmp(nv_cmd.data, 16'h00a5);
    tap(0, 16'h2303, r);
    strobe(16'h3200, 16'h3300, jpcd_pkg::NV_EE_RD, r);
    cmp(r[14:0], res({4'h5, jpcd_pkg::NV_EE_RD}));
  endtask : t_eeprom

  task automatic t_fuse_lock;
    logic [15:0] r;
    tap(0, 16'h2340, r);
    tap(0, 16'h1305, r);
    strobe(16'h3500, 16'h3700, jpcd_pkg::NV_FUSE_HI_WR, r);
    cmp(nv_cmd.data, 16'h0035);
    tap(0, 16'h13c0, r);
    strobe(16'h3100, 16'h3300, jpcd_pkg::NV_FUSE_LO_WR, r);
    cmp(nv_cmd.data, 16'h00f0);
    @(posedge mclk) lock_cur <= 8'hfe;
    tap(0, 16'h2320, r);
    tap(0, 16'h13f3, r);
    strobe(16'h3100, 16'h3300, jpcd_pkg::NV_LOCK_WR, r);
    cmp(nv_cmd.data, 16'h00f2);
  endtask : t_fuse_lock

  task automatic t_reads;
    logic [15:0] r;
    logic [15:0] w[3] = '{16'h3e00, 16'h3200, 16'h3600};
    logic [15:0] p[3] = '{16'h3f00, 16'h3300, 16'h3700};
    jpcd_pkg::jpcd_nv_op_t o[3];
    o = '{jpcd_pkg::NV_FUSE_HI_RD, jpcd_pkg::NV_FUSE_LO_RD, jpcd_pkg::NV_LOCK_RD};
    tap(0, 16'h2304, r);
    for (int i = 0; i < 3; i++) begin
      strobe(w[i], p[i], o[i], r);
      cmp(r[14:0], res({4'h5, o[i]}));
    end
    tap(0, 16'h2308, r);
    tap(0, 16'h0302, r);
    strobe(16'h3200, 16'h3300, jpcd_pkg::NV_SIG_RD, r);
    cmp(nv_cmd.addr, 16'h0002);
    cmp(r[14:0], res({4'h5, jpcd_pkg::NV_SIG_RD}));
    strobe(16'h3600, 16'h3700, jpcd_pkg::NV_CAL_RD, r);
    cmp(r[14:0], res({4'h5, jpcd_pkg::NV_CAL_RD}));
  endtask : t_reads

  task automatic t_leave;
    logic [15:0] r;
    int s0;
    tap(0, 16'h2380, r);
    tap(0, 16'h2300, r);
    tap(0, 16'h3300, r);
    s0 = starts;
    tap(0, 16'h3100, r);
    tap(0, 16'h3300, r);
    cmp(36'(starts - s0), 36'h0);
    tap(1, 16'h0000, r);
    cmp(r, 16'ha370);
    cmp(prog_en, 1'b0);
    tap(0, 16'h2380, r);
    tap(0, 16'h3180, r);
    tap(0, 16'h3380, r);
    cmp(36'(starts - s0), 36'h0);
  endtask : t_leave

  initial begin
    tdi = 1'b0;
    cap = 1'b0;
    sh = 1'b0;
    upd = 1'b0;
    ri = 1'b0;
    sel_en = 1'b0;
    sel_cmd = 1'b0;
    arst_n = 1'b0;
    lock_cur = 8'hff;
    dly = 8'h02;
    cyc = 0;
    repeat (3) @(posedge tck);
    arst_n <= 1'b1;
    t_reset();
    t_enable();
    t_erase();
    t_flash();
    t_eeprom();
    t_fuse_lock();
    t_reads();
    t_leave();
    conclude();
  end
endmodule : test_jtag_prog_command_decoder
